/* bench/rsi_assertions.sv */
`timescale 1ns/1ps
module rsi_assertions
  import rsi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic nav_cmd_valid,
  input wire rsi_nav_cmd_type nav_cmd,
  input wire logic radio_cmd_valid,
  input wire rsi_radio_cmd_type radio_cmd,
  input wire logic radio_take_control,
  input wire logic local_halt_button,
  input wire logic power_on_button,
  input wire logic power_off_button,
  input wire logic enable_switch,
  input wire logic [MOTOR_COUNT-1:0] fast_stop,
  input wire logic [2:0] halt_sources,
  input wire logic motor_ref_valid,
  input wire logic start_relay,
  input wire logic hold_relay,
  input wire logic hold_output,
  input wire logic supply_on,
  input wire logic radio_frame_pulse
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  nav_halt_a: assert property (nav_cmd_valid && nav_cmd == RSI_NAV_HALT |=>
    halt_sources[0] ##1 fast_stop == {MOTOR_COUNT{1'b1}}) else $error("nav halt lost");
  nav_hold_a: assert property (halt_sources[0] && !(nav_cmd_valid &&
    nav_cmd == RSI_NAV_START) |=> halt_sources[0]) else $error("nav halt cleared early");
  radio_halt_a: assert property (radio_cmd_valid && radio_cmd == RSI_RADIO_HALT |=>
    halt_sources[1]) else $error("radio halt lost");
  radio_clear_a: assert property (radio_cmd_valid && radio_cmd == RSI_RADIO_CONTROL |=>
    !halt_sources[1]) else $error("radio halt not cleared");
  local_halt_a: assert property (halt_sources[2] == $past(local_halt_button))
    else $error("local halt latch wrong");
  stop_or_a: assert property (fast_stop == {MOTOR_COUNT{|$past(halt_sources)}})
    else $error("fast stop not or of sources");
  start_relay_a: assert property ($rose(start_relay) |-> $past(enable_switch))
    else $error("start without enable");
  hold_off_a: assert property (power_off_button |=> !hold_relay)
    else $error("hold relay kept");
  hold_fall_a: assert property ($fell(hold_output) && supply_on |->
    $past(radio_cmd_valid) && $past(radio_cmd) == RSI_RADIO_POWER_CUT)
    else $error("hold dropped without cut");
  ref_owner_a: assert property (motor_ref_valid |-> ($past(radio_take_control) ?
    ($past(radio_cmd_valid) && $past(radio_cmd) == RSI_RADIO_CONTROL) :
    ($past(nav_cmd_valid) && $past(nav_cmd) == RSI_NAV_MOTION)))
    else $error("motion from wrong owner");
  start_on_a: assert property (enable_switch && power_on_button |=> start_relay)
    else $error("start relay not closed");
  frame_pace_a: assert property (radio_frame_pulse |=> radio_cmd_valid)
    else $error("radio frame not sent");
endmodule // rsi_assertions

/* bench/tb_robot_stop_and_power_interlock.sv */
`timescale 1ns/1ps
module tb_robot_stop_and_power_interlock;
  import rsi_pkg::*;
  // a little over one radio frame, so a remote command surely lands
  localparam int FRAME = RADIO_PERIOD_CYCLES + 100;
  localparam logic [MOTION_W-1:0] ALL = MOTION_W'({MOTOR_COUNT{1'b1}});
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic nav_halt_req = 1'b0, nav_start_req = 1'b0, nav_motion_req = 1'b0;
  logic remote_halt_button = 1'b0, remote_take_button = 1'b0, remote_power_cut_button = 1'b0;
  logic chassis_halt_button = 1'b0, chassis_on_button = 1'b0, chassis_off_button = 1'b0;
  logic chassis_enable_switch = 1'b0, chassis_motor_switch = 1'b0;
  logic [MOTION_W-1:0] nav_motion_data = 16'h0000, remote_motion_data = 16'h0000;
  logic [MOTOR_COUNT-1:0] fast_stop;
  logic [MOTION_W-1:0] motor_ref;
  logic [2:0] halt_sources;
  logic motor_power_on, motor_ref_valid, radio_in_control, start_relay, hold_relay;
  logic hold_output, supply_on, radio_frame_pulse;
  int checks = 0;
  int bad_count = 0;

  rsi_link_if link ();
  rsi_partner rsi_partner_i (.sys_clk, .rst_n, .link(link), .nav_halt_req, .nav_start_req,
    .nav_motion_req, .nav_motion_data, .remote_halt_button, .remote_take_button,
    .remote_power_cut_button, .remote_motion_data, .chassis_halt_button, .chassis_on_button,
    .chassis_off_button, .chassis_enable_switch, .chassis_motor_switch, .radio_frame_pulse);
  rsi_device rsi_device_i (.sys_clk, .rst_n, .link(link), .fast_stop, .motor_power_on,
    .motor_ref, .motor_ref_valid, .radio_in_control, .halt_sources, .start_relay,
    .hold_relay, .hold_output, .supply_on);
  rsi_assertions rsi_assertions_i (.sys_clk, .rst_n, .nav_cmd_valid(link.nav_cmd_valid),
    .nav_cmd(link.nav_cmd), .radio_cmd_valid(link.radio_cmd_valid),
    .radio_cmd(link.radio_cmd), .radio_take_control(link.radio_take_control),
    .local_halt_button(link.local_halt_button), .power_on_button(link.power_on_button),
    .power_off_button(link.power_off_button), .enable_switch(link.enable_switch),
    .fast_stop, .halt_sources, .motor_ref_valid, .start_relay, .hold_relay, .hold_output,
    .supply_on, .radio_frame_pulse);

  always #2.5 sys_clk = ~sys_clk;

  // inputs always move 1 ns after the edge, away from sampling
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task check(input logic [MOTION_W-1:0] seen, input logic [MOTION_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task s_nav();
    nav_halt_req = 1'b1;
    tick(1);
    nav_halt_req = 1'b0;
    tick(6);
    check(MOTION_W'(fast_stop), ALL);
    nav_start_req = 1'b1;
    tick(1);
    nav_start_req = 1'b0;
    tick(6);
    check(MOTION_W'(fast_stop), 16'h0000);
  endtask

  task s_local();
    chassis_motor_switch = 1'b1;
    chassis_halt_button = 1'b1;
    tick(5);
    check(MOTION_W'(fast_stop), ALL);
    check(MOTION_W'(motor_power_on), 16'h0001);
    chassis_halt_button = 1'b0;
    chassis_motor_switch = 1'b0;
    tick(5);
    check(MOTION_W'(fast_stop), 16'h0000);
    check(MOTION_W'(motor_power_on), 16'h0000);
  endtask

  // a local press and release in mid radio halt must not clear it
  task s_radio();
    remote_halt_button = 1'b1;
    tick(FRAME);
    check(MOTION_W'(fast_stop), ALL);
    chassis_halt_button = 1'b1;
    tick(5);
    chassis_halt_button = 1'b0;
    tick(5);
    check(MOTION_W'(fast_stop), ALL);
    remote_halt_button = 1'b0;
    tick(FRAME);
    check(MOTION_W'(fast_stop), 16'h0000);
  endtask

  task s_motion();
    remote_motion_data = 16'h0F0F;
    nav_motion_data = 16'hA5C3;
    nav_motion_req = 1'b1;
    tick(1);
    nav_motion_req = 1'b0;
    tick(1);
    check(MOTION_W'(motor_ref_valid), 16'h0001);
    tick(1);
    check(MOTION_W'(motor_ref_valid), 16'h0000);
    tick(FRAME);
    check(motor_ref, 16'hA5C3);
    remote_take_button = 1'b1;
    remote_motion_data = 16'h5A5A;
    tick(FRAME);
    check(motor_ref, 16'h5A5A);
    check(MOTION_W'(radio_in_control), 16'h0001);
    nav_motion_data = 16'h1234;
    nav_motion_req = 1'b1;
    tick(1);
    nav_motion_req = 1'b0;
    tick(5);
    check(motor_ref, 16'h5A5A);
    remote_take_button = 1'b0;
  endtask

  task press_on();
    chassis_on_button = 1'b1;
    tick(7);
    chassis_on_button = 1'b0;
    tick(5);
  endtask

  task s_power();
    press_on();
    check(MOTION_W'(start_relay), 16'h0000);
    check(MOTION_W'(radio_in_control), 16'h0000);
    chassis_enable_switch = 1'b1;
    chassis_on_button = 1'b1;
    tick(3);
    check(MOTION_W'(start_relay), 16'h0001);
    tick(4);
    chassis_on_button = 1'b0;
    tick(5);
    check(MOTION_W'(supply_on), 16'h0001);
    check(MOTION_W'(hold_output), 16'h0001);
    chassis_off_button = 1'b1;
    tick(3);
    chassis_off_button = 1'b0;
    tick(5);
    check(MOTION_W'(supply_on), 16'h0000);
    check(MOTION_W'(hold_relay), 16'h0000);
    press_on();
    check(MOTION_W'(supply_on), 16'h0001);
    remote_power_cut_button = 1'b1;
    tick(FRAME);
    check(MOTION_W'(hold_output), 16'h0000);
    check(MOTION_W'(supply_on), 16'h0000);
    remote_power_cut_button = 1'b0;
  endtask

  // longest path is a handful of radio frames; this leaves ample margin
  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  initial begin
    tick(2);
    rst_n = 1'b1;
    tick(2);
    s_nav();
    s_local();
    s_radio();
    s_motion();
    s_power();
    summarize();
  end
endmodule // tb_robot_stop_and_power_interlock

/* hdl/rsi_device.sv */
`timescale 1ns/1ps
// How it works
// R01 - computer halt command raises fast-stop outputs
// R02 - only computer start clears computer halt
// R03 - radio halt command raises fast-stop outputs
// R04 - radio control command clears radio halt
// R05 - local halt button held raises fast-stop
// R06 - local button release drops its fast-stop
// R07 - computer in control: radio motion discarded
// R08 - fast-stop brakes; motor power off frees
// R09 - power-on needs rotary enable switch
// R10 - power-on button energizes the start relay
// R11 - powered receiver raises hold, latching supply
// R12 - off button or low hold drops relays
// R13 - hold and button path joined by AND
// R14 - hold falls only on power-cut command
// R15 - remote sends power-cut on button press
// R16 - radio take-control overrides computer motion
// R17 - fast-stop is OR of three halt sources
module rsi_device
  import rsi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  rsi_link_if.device link,
  output logic [MOTOR_COUNT-1:0] fast_stop,
  output logic motor_power_on,
  output logic [MOTION_W-1:0] motor_ref,
  output logic motor_ref_valid,
  output logic radio_in_control,
  output logic [2:0] halt_sources,
  output logic start_relay,
  output logic hold_relay,
  output logic hold_output,
  output logic supply_on
);

  logic nav_halt_reg;
  logic radio_halt_reg;
  logic local_halt_reg;
  logic fast_stop_reg;
  logic [MOTION_W-1:0] motor_ref_reg;
  logic motor_ref_valid_reg;
  logic motor_power_reg;
  logic start_relay_reg;
  logic hold_relay_reg;
  logic hold_output_reg;
  logic power_cut_reg;
  logic radio_ctrl_reg;
  logic nav_halt_cmd;
  logic nav_start_cmd;
  logic nav_motion_cmd;
  logic radio_halt_cmd;
  logic radio_control_cmd;
  logic radio_cut_cmd;
  logic relay_keep;

  // command decode; strobes are single cycles from the link
  assign nav_halt_cmd = link.nav_cmd_valid && (link.nav_cmd == RSI_NAV_HALT);
  assign nav_start_cmd = link.nav_cmd_valid && (link.nav_cmd == RSI_NAV_START);
  assign nav_motion_cmd = link.nav_cmd_valid && (link.nav_cmd == RSI_NAV_MOTION);
  assign radio_halt_cmd = link.radio_cmd_valid && (link.radio_cmd == RSI_RADIO_HALT);
  assign radio_control_cmd = link.radio_cmd_valid && (link.radio_cmd == RSI_RADIO_CONTROL);
  assign radio_cut_cmd = link.radio_cmd_valid && (link.radio_cmd == RSI_RADIO_POWER_CUT);

  // computer halt latch: only a start clears it, a halt in the same cycle wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nav_halt_reg <= 1'b0;
    end else if (nav_halt_cmd) begin
      nav_halt_reg <= 1'b1; // R01
    end else if (nav_start_cmd) begin
      nav_halt_reg <= 1'b0; // R02
    end
  end

  // radio halt latch: halt frames keep it set, a control frame clears it.
  // halt is honoured whoever owns motion, so the owner is not looked at here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      radio_halt_reg <= 1'b0;
    end else if (radio_halt_cmd) begin
      radio_halt_reg <= 1'b1; // R03 R07
    end else if (radio_control_cmd) begin
      radio_halt_reg <= 1'b0; // R04
    end
  end

  // local button is wired straight in: a pure level, no latch behind it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      local_halt_reg <= 1'b0;
    end else begin
      local_halt_reg <= link.local_halt_button; // R05 R06
    end
  end

  // fast-stop drives every motor driver at once; any source holds it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_stop_reg <= 1'b0;
    end else begin
      fast_stop_reg <= nav_halt_reg | radio_halt_reg | local_halt_reg; // R17
    end
  end

  // all drivers share one stop level; the status bits tell which source holds it
  assign fast_stop = fast_stop_reg ? {MOTOR_COUNT{1'b1}} : FAST_STOP_RESET; // R08
  assign halt_sources = {local_halt_reg, radio_halt_reg, nav_halt_reg};

  // motor power is a separate switch: off lets the wheels free-wheel,
  // unlike fast-stop which brakes and holds
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_power_reg <= 1'b0;
    end else begin
      motor_power_reg <= link.motor_enable_switch; // R08
    end
  end

  assign motor_power_on = motor_power_reg;

  // motion arbitration: the take-control level selects the radio remote,
  // otherwise only computer motion gets through and radio motion is dropped.
  // references still flow during fast-stop; the drivers ignore them while held
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_ref_reg <= MOTION_RESET;
      motor_ref_valid_reg <= 1'b0;
    end else if (link.radio_take_control) begin
      motor_ref_valid_reg <= radio_control_cmd; // R16
      if (radio_control_cmd) begin
        motor_ref_reg <= link.radio_motion;
      end
    end else begin
      motor_ref_valid_reg <= nav_motion_cmd; // R07
      if (nav_motion_cmd) begin
        motor_ref_reg <= link.nav_motion;
      end
    end
  end

  assign motor_ref = motor_ref_reg;
  assign motor_ref_valid = motor_ref_valid_reg;

  // owner flag for the panel, registered like the other status outputs;
  // it lags the link by one cycle, which a display does not notice
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      radio_ctrl_reg <= 1'b0;
    end else begin
      radio_ctrl_reg <= link.radio_take_control; // R16
    end
  end

  assign radio_in_control = radio_ctrl_reg;

  // start relay: closes from the button or through the hold relay contact,
  // and only while the rotary switch feeds the board
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_relay_reg <= 1'b0;
    end else begin
      start_relay_reg <= link.enable_switch & (link.power_on_button | hold_relay_reg); // R09 R10
    end
  end

  assign supply_on = start_relay_reg;

  // hold path: receiver hold output ANDed with the off button path.
  // releasing the hold relay drops the start relay one cycle later
  assign relay_keep = hold_output_reg & ~link.power_off_button; // R13

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_relay_reg <= 1'b0;
    end else begin
      hold_relay_reg <= start_relay_reg & relay_keep; // R11 R12
    end
  end

  // power-cut latch lives in the receiver, which loses power with the supply;
  // that is the only way it forgets a cut
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_cut_reg <= 1'b0;
    end else if (!start_relay_reg) begin
      power_cut_reg <= 1'b0;
    end else if (radio_cut_cmd) begin
      power_cut_reg <= 1'b1; // R14
    end
  end

  // hold output: high once powered, low only after a cut command
  // (an unpowered receiver drives nothing, so it also reads low then)
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_output_reg <= 1'b0;
    end else begin
      hold_output_reg <= start_relay_reg & ~power_cut_reg & ~radio_cut_cmd; // R11 R14
    end
  end

  assign start_relay = start_relay_reg;
  assign hold_relay = hold_relay_reg;
  assign hold_output = hold_output_reg;

endmodule // rsi_device

/* hdl/rsi_link_if.sv */
`timescale 1ns/1ps
interface rsi_link_if;
  import rsi_pkg::*;

  // navigation computer to motor controller
  logic nav_cmd_valid;
  rsi_nav_cmd_type nav_cmd;
  logic [MOTION_W-1:0] nav_motion;
  // radio remote to motor controller and power receiver
  logic radio_cmd_valid;
  rsi_radio_cmd_type radio_cmd;
  logic radio_take_control;
  logic [MOTION_W-1:0] radio_motion;
  // operator buttons and switches on the chassis, levels, high = pressed
  logic local_halt_button;
  logic power_on_button;
  logic power_off_button;
  logic enable_switch;
  logic motor_enable_switch;

  modport device (
    input nav_cmd_valid, nav_cmd, nav_motion,
    input radio_cmd_valid, radio_cmd, radio_take_control, radio_motion,
    input local_halt_button, power_on_button, power_off_button,
    input enable_switch, motor_enable_switch
  );

  modport partner (
    output nav_cmd_valid, nav_cmd, nav_motion,
    output radio_cmd_valid, radio_cmd, radio_take_control, radio_motion,
    output local_halt_button, power_on_button, power_off_button,
    output enable_switch, motor_enable_switch
  );

endinterface

/* hdl/rsi_partner.sv */
`timescale 1ns/1ps
module rsi_partner
  import rsi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  rsi_link_if.partner link,
  input wire logic nav_halt_req,
  input wire logic nav_start_req,
  input wire logic nav_motion_req,
  input wire logic [MOTION_W-1:0] nav_motion_data,
  input wire logic remote_halt_button,
  input wire logic remote_take_button,
  input wire logic remote_power_cut_button,
  input wire logic [MOTION_W-1:0] remote_motion_data,
  input wire logic chassis_halt_button,
  input wire logic chassis_on_button,
  input wire logic chassis_off_button,
  input wire logic chassis_enable_switch,
  input wire logic chassis_motor_switch,
  output logic radio_frame_pulse
);

  localparam logic [RADIO_CNT_W-1:0] RADIO_LAST = RADIO_CNT_W'(RADIO_PERIOD_CYCLES - 1);

  logic [RADIO_CNT_W-1:0] radio_cnt_reg;
  logic radio_tick;

  // navigation computer: a halt request outranks start, start outranks motion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.nav_cmd_valid <= 1'b0;
      link.nav_cmd <= RSI_NAV_IDLE;
      link.nav_motion <= MOTION_RESET;
    end else begin
      link.nav_cmd_valid <= nav_halt_req | nav_start_req | nav_motion_req;
      if (nav_halt_req) begin
        link.nav_cmd <= RSI_NAV_HALT; // R01
      end else if (nav_start_req) begin
        link.nav_cmd <= RSI_NAV_START; // R02
      end else if (nav_motion_req) begin
        link.nav_cmd <= RSI_NAV_MOTION;
        link.nav_motion <= nav_motion_data;
      end else begin
        link.nav_cmd <= RSI_NAV_IDLE;
      end
    end
  end

  // radio frame divider: the remote sends one command per frame slot; take-control passes every cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      radio_cnt_reg <= '0;
    end else if (radio_cnt_reg == RADIO_LAST) begin
      radio_cnt_reg <= '0;
    end else begin
      radio_cnt_reg <= radio_cnt_reg + 1'b1;
    end
  end

  assign radio_tick = (radio_cnt_reg == RADIO_LAST);
  assign radio_frame_pulse = radio_tick;

  // radio remote: power cut first, then halt while held, else control frames
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.radio_cmd_valid <= 1'b0;
      link.radio_cmd <= RSI_RADIO_IDLE;
      link.radio_motion <= MOTION_RESET;
      link.radio_take_control <= 1'b0;
    end else begin
      link.radio_cmd_valid <= radio_tick;
      link.radio_take_control <= remote_take_button;
      if (radio_tick) begin
        if (remote_power_cut_button) begin
          link.radio_cmd <= RSI_RADIO_POWER_CUT; // R15
        end else if (remote_halt_button) begin
          link.radio_cmd <= RSI_RADIO_HALT; // R03
        end else begin
          link.radio_cmd <= RSI_RADIO_CONTROL; // R04
          link.radio_motion <= remote_motion_data;
        end
      end else begin
        link.radio_cmd <= RSI_RADIO_IDLE;
      end
    end
  end

  // chassis buttons are plain levels, registered once before they reach the board
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.local_halt_button <= 1'b0;
      link.power_on_button <= 1'b0;
      link.power_off_button <= 1'b0;
      link.enable_switch <= 1'b0;
      link.motor_enable_switch <= 1'b0;
    end else begin
      link.local_halt_button <= chassis_halt_button;
      link.power_on_button <= chassis_on_button;
      link.power_off_button <= chassis_off_button;
      link.enable_switch <= chassis_enable_switch;
      link.motor_enable_switch <= chassis_motor_switch;
    end
  end

endmodule // rsi_partner

/* hdl/rsi_pkg.sv */
package rsi_pkg;

  // number of motor drivers that share the fast-stop line
  localparam int MOTOR_COUNT = 4;
  // width of one motion reference word (speed and width packed)
  localparam int MOTION_W = 16;

  // navigation computer command codes
  typedef enum logic [1:0] {
    RSI_NAV_IDLE = 2'h0,
    RSI_NAV_HALT = 2'h1,
    RSI_NAV_START = 2'h2,
    RSI_NAV_MOTION = 2'h3
  } rsi_nav_cmd_type;

  // radio remote command codes
  typedef enum logic [1:0] {
    RSI_RADIO_IDLE = 2'h0,
    RSI_RADIO_HALT = 2'h1,
    RSI_RADIO_CONTROL = 2'h2,
    RSI_RADIO_POWER_CUT = 2'h3
  } rsi_radio_cmd_type;

  // clock and radio frame pacing of the remote unit
  localparam int CLK_MHZ = 200;
  localparam int RADIO_PERIOD_US = 10;
  localparam int RADIO_PERIOD_CYCLES = RADIO_PERIOD_US * CLK_MHZ;
  localparam int RADIO_CNT_W = 12;

  // reset values
  localparam logic [MOTOR_COUNT-1:0] FAST_STOP_RESET = 4'h0;
  localparam logic [MOTION_W-1:0] MOTION_RESET = 16'h0000;

endpackage
